// file: pkg/hbs_pkg.sv
package hbs_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // ----------------------------------------------------------------
  // Timing figures and derived cycle counts
  // ----------------------------------------------------------------
  localparam int unsigned INT_FREQ_HZ = 425_000;
  localparam int unsigned INT_HALF_CYC = CLK_HZ / (2 * INT_FREQ_HZ);

  localparam int unsigned WDOG_NS = 20_000;
  localparam int unsigned WDOG_CYC =
    (WDOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned DEAD_NS = 30;
  localparam int unsigned DEAD_RAW =
    (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_CYC = (DEAD_RAW < 1) ? 1 : DEAD_RAW;

  localparam int unsigned BLANK_US = 1200;
  localparam int unsigned BLANK_CYC_DEF = BLANK_US * 1000 / CLK_PERIOD_NS;

  localparam int unsigned RETRY_US = 38400;
  localparam int unsigned RETRY_CYC_DEF = RETRY_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Counter widths
  // ----------------------------------------------------------------
  localparam int unsigned OSC_W = 5;
  localparam int unsigned WDOG_W = 9;
  localparam int unsigned GAP_W = 2;
  localparam int unsigned CNT_W = 20;

  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(INT_HALF_CYC - 1);
  localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(WDOG_CYC - 1);
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(DEAD_CYC - 1);

  // ----------------------------------------------------------------
  // Synchronised input positions
  // ----------------------------------------------------------------
  localparam int unsigned SYN_W = 6;
  localparam int unsigned SYN_CLK = 0;
  localparam int unsigned SYN_EN_N = 1;
  localparam int unsigned SYN_UVLO = 2;
  localparam int unsigned SYN_ILIM = 3;
  localparam int unsigned SYN_HOT = 4;
  localparam int unsigned SYN_COOL = 5;

  // ----------------------------------------------------------------
  // Protection state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_RUN = 4'b0010,
    ST_OC_RETRY = 4'b0100,
    ST_THERM = 4'b1000
  } hbs_state_e;

endpackage

// file: pkg/hbs_phase_if.sv
`timescale 1ns/1ps
interface hbs_phase_if;
  logic phase;
  logic ext_mode;

  modport src (
    output phase,
    output ext_mode
  );

  modport snk (
    input phase,
    input ext_mode
  );
endinterface

// file: rtl/hbs_sync.sv
`timescale 1ns/1ps
module hbs_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input logic mclk,
  input logic resetn,
  // Asynchronous levels in, synchronised levels out
  input logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hbs_sync_s;

  hbs_sync_s r;
  hbs_sync_s n;

  always_comb begin
    n = r;
    n.s1 = async_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_o = r.s2;

endmodule

// file: rtl/hbs_clk_select.sv
`timescale 1ns/1ps
module hbs_clk_select
  import hbs_pkg::*;
(
  // Clock and reset
  input logic mclk,
  input logic resetn,
  // Synchronised clock pin level
  input logic clk_in_s,
  // Phase towards the bridge logic
  hbs_phase_if.src ph
);

  typedef struct packed {
    logic prev;
    logic ext_mode;
    logic phase;
    logic [OSC_W-1:0] osc;
    logic [WDOG_W-1:0] wdog;
  } hbs_clksel_s;

  hbs_clksel_s r;
  hbs_clksel_s n;
  logic rise;
  logic any_edge;

  always_comb begin
    n = r;
    rise = clk_in_s & ~r.prev;
    any_edge = clk_in_s ^ r.prev;
    n.prev = clk_in_s;

    // --------------------------------------------------------------
    // Watchdog on the spacing of pin edges
    // --------------------------------------------------------------
    if (any_edge) begin
      n.wdog = '0;
      n.ext_mode = 1'b1;
    end else if (r.wdog == WDOG_LAST) begin
      n.ext_mode = 1'b0;
    end else begin
      n.wdog = r.wdog + 1'b1;
    end

    // --------------------------------------------------------------
    // Phase source
    // --------------------------------------------------------------
    if (r.ext_mode) begin
      n.osc = '0;
      if (rise) begin
        n.phase = ~r.phase;
      end
    end else if (r.osc == OSC_LAST) begin
      n.osc = '0;
      n.phase = ~r.phase;
    end else begin
      n.osc = r.osc + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ph.phase = r.phase;
  assign ph.ext_mode = r.ext_mode;

endmodule

// file: rtl/hbs_top.sv
// Functional notes
// - Grounded clock pin: internal oscillator; applied clock: external mode.
// - Internal mode toggles outputs at about 425 kHz, 50% duty.
// - External mode divides the pin clock by two.
// - External mode changes phase only on rising pin edges.
// - Watchdog falls back to internal oscillator after 20 us without edges.
// - Both outputs float for a dead time at every transition.
// - Disable mode floats both outputs and stops switching.
// - Supply below lockout threshold forces disable mode.
// - Current at limit past 1.2 ms blanking disables drivers, asserts fault.
// - Drivers re-enable automatically after 38.4 ms autoretry.
// - Fault released on autoretry re-enable; toggles under overcurrent.
// - Fault driven low only while disabled by a fault.
// - Overtemperature above 160 C disables, fault low; resume below 150 C.
// - Enable input is active low; high means disable mode.
`timescale 1ns/1ps
module hbs_top
  import hbs_pkg::*;
#(
  parameter int unsigned BLANK_CYC = BLANK_CYC_DEF,
  parameter int unsigned RETRY_CYC = RETRY_CYC_DEF
) (
  // Clock and reset
  input logic mclk,
  input logic resetn,
  // Clock source pin
  input logic clk_in,
  // Control and analog comparator levels
  input logic enable_n,
  input logic supply_low,
  input logic current_at_limit,
  input logic temp_above_shdn,
  input logic temp_below_resume,
  // Bridge outputs
  output logic bridge_out_a,
  output logic bridge_out_a_oe,
  output logic bridge_out_b,
  output logic bridge_out_b_oe,
  // Open-drain fault output
  output logic fault_n,
  output logic fault_n_oe
);

  localparam logic [CNT_W-1:0] BLANK_LAST = CNT_W'(BLANK_CYC - 1);
  localparam logic [CNT_W-1:0] RETRY_LAST = CNT_W'(RETRY_CYC - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYN_W-1:0] pins;
  logic [SYN_W-1:0] pins_s;

  assign pins[SYN_CLK] = clk_in;
  // Both control levels enter the synchroniser inverted, so that its
  // cleared state just after reset reads as disabled, never as running.
  assign pins[SYN_EN_N] = ~enable_n;
  assign pins[SYN_UVLO] = ~supply_low;
  assign pins[SYN_ILIM] = current_at_limit;
  assign pins[SYN_HOT] = temp_above_shdn;
  assign pins[SYN_COOL] = temp_below_resume;

  hbs_sync #(
    .W(SYN_W)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_i(pins),
    .sync_o(pins_s)
  );

  // ----------------------------------------------------------------
  // Clock source selection and phase generation
  // ----------------------------------------------------------------
  hbs_phase_if ph ();

  hbs_clk_select u_clk_select (
    .mclk(mclk),
    .resetn(resetn),
    .clk_in_s(pins_s[SYN_CLK]),
    .ph(ph)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hbs_state_e state;
    logic therm;
    logic [CNT_W-1:0] blank;
    logic [CNT_W-1:0] retry;
    logic applied;
    logic [GAP_W-1:0] gap;
    logic out_a;
    logic out_a_oe;
    logic out_b;
    logic out_b_oe;
    logic fault;
    logic fault_oe;
  } hbs_top_s;

  localparam hbs_top_s RESET_VAL = '{
    state: ST_OFF,
    therm: 1'b0,
    blank: '0,
    retry: '0,
    applied: 1'b0,
    gap: GAP_LOAD,
    out_a: 1'b0,
    out_a_oe: 1'b0,
    out_b: 1'b1,
    out_b_oe: 1'b0,
    fault: 1'b0,
    fault_oe: 1'b0
  };

  hbs_top_s r;
  hbs_top_s n;
  logic off_cond;
  logic at_limit;
  logic run;
  logic drive;

  always_comb begin
    n = r;
    off_cond = ~pins_s[SYN_EN_N] | ~pins_s[SYN_UVLO];
    at_limit = pins_s[SYN_ILIM];
    run = (r.state == ST_RUN);
    drive = 1'b0;

    // --------------------------------------------------------------
    // Thermal hysteresis, setting wins over clearing
    // --------------------------------------------------------------
    if (pins_s[SYN_HOT]) begin
      n.therm = 1'b1;
    end else if (pins_s[SYN_COOL]) begin
      n.therm = 1'b0;
    end

    // --------------------------------------------------------------
    // Protection state machine
    // --------------------------------------------------------------
    if (off_cond) begin
      n.state = ST_OFF;
      n.blank = '0;
      n.retry = '0;
    end else if (n.therm) begin
      n.state = ST_THERM;
      n.blank = '0;
      n.retry = '0;
    end else begin
      unique case (r.state)
        ST_OFF, ST_THERM: begin
          n.state = ST_RUN;
          n.blank = '0;
        end
        ST_RUN: begin
          if (!at_limit) begin
            n.blank = '0;
          end else if (r.blank == BLANK_LAST) begin
            n.state = ST_OC_RETRY;
            n.blank = '0;
            n.retry = '0;
          end else begin
            n.blank = r.blank + 1'b1;
          end
        end
        ST_OC_RETRY: begin
          if (r.retry == RETRY_LAST) begin
            n.state = ST_RUN;
            n.retry = '0;
          end else begin
            n.retry = r.retry + 1'b1;
          end
        end
      endcase
    end

    // --------------------------------------------------------------
    // Dead-time gap and complementary drive
    // --------------------------------------------------------------
    if (!run) begin
      n.applied = ph.phase;
      n.gap = GAP_LOAD;
    end else if (ph.phase != r.applied) begin
      n.applied = ph.phase;
      n.gap = GAP_LOAD;
    end else if (r.gap != '0) begin
      n.gap = r.gap - 1'b1;
    end else begin
      drive = 1'b1;
    end
    n.out_a = n.applied;
    n.out_b = ~n.applied;
    n.out_a_oe = drive;
    n.out_b_oe = drive;

    // --------------------------------------------------------------
    // Fault pin pulls low only for fault-caused disable
    // --------------------------------------------------------------
    n.fault = 1'b0;
    n.fault_oe = n.therm | (n.state == ST_OC_RETRY);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      r <= RESET_VAL;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bridge_out_a = r.out_a;
  assign bridge_out_a_oe = r.out_a_oe;
  assign bridge_out_b = r.out_b;
  assign bridge_out_b_oe = r.out_b_oe;
  assign fault_n = r.fault;
  assign fault_n_oe = r.fault_oe;

endmodule

// file: testbench/hbs_clk_src.sv
`timescale 1ns/1ps
module hbs_clk_src #(
  parameter int HALF_NS = 400
) (
  // Control
  input wire logic run,
  // Clock pin
  output logic clk_in
);
  // The pin rests low between bursts.
  // The 13 ns offset keeps pin edges away from system clock edges.
  always begin
    if (run === 1'b1) begin
      #(HALF_NS) clk_in = ~clk_in;
    end else begin
      clk_in = 1'b0;
      @(run);
      #13;
    end
  end
endmodule

// file: testbench/hbs_properties.sv
`timescale 1ns/1ps
module hbs_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Inputs
  input wire logic enable_n,
  input wire logic supply_low,
  input wire logic temp_above_shdn,
  // Outputs
  input wire logic bridge_out_a,
  input wire logic bridge_out_a_oe,
  input wire logic bridge_out_b,
  input wire logic bridge_out_b_oe,
  input wire logic fault_n,
  input wire logic fault_n_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_compl; bridge_out_b == !bridge_out_a; endproperty
  a_compl: assert property (p_compl) else $error("b not ~a");
  property p_oe; bridge_out_a_oe == bridge_out_b_oe; endproperty
  a_oe: assert property (p_oe) else $error("oe differ");
  property p_od; fault_n == 1'b0; endproperty
  a_od: assert property (p_od) else $error("fault data high");
  property p_gap;
    bridge_out_a_oe && $changed(bridge_out_a) |-> !$past(bridge_out_a_oe);
  endproperty
  a_gap: assert property (p_gap) else $error("no dead gap");
  property p_dis; enable_n [*5] |-> !bridge_out_a_oe; endproperty
  a_dis: assert property (p_dis) else $error("driven off");
  property p_uv; supply_low [*5] |-> !bridge_out_a_oe; endproperty
  a_uv: assert property (p_uv) else $error("driven in lockout");
  property p_hot; temp_above_shdn [*4] |-> fault_n_oe; endproperty
  a_hot: assert property (p_hot) else $error("hot no fault");
  property p_flt;
    fault_n_oe && $past(fault_n_oe) |-> !bridge_out_a_oe;
  endproperty
  a_flt: assert property (p_flt) else $error("driven in fault");
endmodule

bind hbs_top hbs_properties hbs_properties_inst (
  .mclk(mclk), .resetn(resetn), .enable_n(enable_n),
  .supply_low(supply_low), .temp_above_shdn(temp_above_shdn),
  .bridge_out_a(bridge_out_a), .bridge_out_a_oe(bridge_out_a_oe),
  .bridge_out_b(bridge_out_b), .bridge_out_b_oe(bridge_out_b_oe),
  .fault_n(fault_n), .fault_n_oe(fault_n_oe)
);

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb import hbs_pkg::*; ;
  localparam int BLANK = 20;
  localparam int RETRY = 100;
  localparam int H_NS = 400;
  logic mclk, resetn, clk_in, enable_n, supply_low, current_at_limit;
  logic temp_above_shdn, temp_below_resume, run;
  logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe;
  logic fault_n, fault_n_oe;
  int fails = 0;
  int comparisons = 0;
  // The fault line has a pull-up on the board.
  wire fault_pin = fault_n_oe ? fault_n : 1'b1;

  hbs_top #(.BLANK_CYC(BLANK), .RETRY_CYC(RETRY)) hbs_top_inst (
    .mclk(mclk), .resetn(resetn), .clk_in(clk_in), .enable_n(enable_n),
    .supply_low(supply_low), .current_at_limit(current_at_limit),
    .temp_above_shdn(temp_above_shdn),
    .temp_below_resume(temp_below_resume),
    .bridge_out_a(bridge_out_a), .bridge_out_a_oe(bridge_out_a_oe),
    .bridge_out_b(bridge_out_b), .bridge_out_b_oe(bridge_out_b_oe),
    .fault_n(fault_n), .fault_n_oe(fault_n_oe)
  );
  hbs_clk_src #(.HALF_NS(H_NS)) hbs_clk_src_inst (
    .run(run), .clk_in(clk_in)
  );

  initial mclk = 1'b0;
  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %0d got %0d", nm, e, g);
    end
  endtask

  // Cycles between two successive changes of output A.
  task automatic gap(output int n);
    logic p;
    int k;
    k = 0;
    @(posedge mclk);
    p = bridge_out_a;
    while (bridge_out_a === p && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    p = bridge_out_a;
    n = 0;
    while (bridge_out_a === p && n < 2000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic watch(input int k, output logic drv, flt);
    drv = 1'b0;
    flt = 1'b0;
    repeat (k) begin
      @(posedge mclk);
      drv |= bridge_out_a_oe;
      flt |= !fault_pin;
    end
  endtask

  task automatic t_int();
    int n;
    gap(n);
    chk("int_half", INT_HALF_CYC, n);
  endtask

  task automatic t_ext();
    int n;
    run <= 1'b1;
    repeat (60) @(posedge mclk);
    gap(n);
    chk("ext_half", 2 * H_NS / CLK_PERIOD_NS, n);
    run <= 1'b0;
    repeat (700) @(posedge mclk);
    gap(n);
    chk("wdog_half", INT_HALF_CYC, n);
  endtask

  task automatic t_off(input bit uv);
    logic d, f;
    @(posedge mclk);
    if (uv) supply_low <= 1'b1;
    else enable_n <= 1'b1;
    repeat (5) @(posedge mclk);
    watch(60, d, f);
    chk("off_drive", 0, d);
    chk("off_fault", 0, f);
    supply_low <= 1'b0;
    enable_n <= 1'b0;
    watch(40, d, f);
    chk("on_drive", 1, d);
  endtask

  task automatic t_oc();
    int n;
    logic d, f;
    repeat (2) begin
      @(posedge mclk);
      current_at_limit <= 1'b1;
      repeat (BLANK - 2) @(posedge mclk);
      current_at_limit <= 1'b0;
    end
    watch(6, d, f);
    chk("blank_restart", 0, f);
    current_at_limit <= 1'b1;
    n = 0;
    while (fault_pin !== 1'b0 && n < BLANK + 10) begin
      @(posedge mclk);
      n++;
    end
    chk("blank_len", 1, n >= BLANK && n <= BLANK + 5);
    n = 0;
    while (fault_pin === 1'b0 && n < RETRY + 10) begin
      @(posedge mclk);
      n++;
    end
    chk("retry_len", 1, n >= RETRY - 1 && n <= RETRY + 1);
    watch(BLANK + 8, d, f);
    chk("refault", 1, f);
    current_at_limit <= 1'b0;
    repeat (RETRY + 10) @(posedge mclk);
    watch(40, d, f);
    chk("oc_clear", 0, f);
    chk("oc_drive", 1, d);
  endtask

  task automatic t_hot();
    logic d, f;
    @(posedge mclk);
    temp_above_shdn <= 1'b1;
    temp_below_resume <= 1'b0;
    repeat (5) @(posedge mclk);
    watch(40, d, f);
    chk("hot_drive", 0, d);
    chk("hot_fault", 0, fault_pin);
    temp_above_shdn <= 1'b0;
    watch(20, d, f);
    chk("hyst_fault", 0, fault_pin);
    temp_below_resume <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("cool_fault", 1, fault_pin);
    watch(40, d, f);
    chk("cool_drive", 1, d);
  endtask

  initial begin
    resetn = 1'b0;
    enable_n = 1'b1;
    supply_low = 1'b0;
    current_at_limit = 1'b0;
    temp_above_shdn = 1'b0;
    temp_below_resume = 1'b1;
    run = 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    enable_n <= 1'b0;
    repeat (10) @(posedge mclk);
    t_int();
    t_ext();
    t_off(1'b0);
    t_off(1'b1);
    t_oc();
    t_hot();
    conclude();
  end

  initial begin
    #1_000_000;
    fails++;
    conclude();
  end
endmodule
